// ### design/pst_protector_selftest.sv
// Protector self-test engines, fault flags and register bank
module pst_protector_selftest
  import pst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire pst_apb_req_t i_apb,
  input wire pst_ana_in_t i_ana,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output pst_ana_out_t o_ana,
  output logic o_fault_out_n
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [NPROT-1:0][31:0] cfg;
    logic [ST_W-1:0] stat;
    logic [NPROT-1:0][NCH-1:0] lo_flg;
    logic [NPROT-1:0][NCH-1:0] hi_flg;
    pst_eng_t [NPROT-1:0] eng;
    logic [NPROT-1:0][1:0] mode;
    logic [NPROT-1:0][3:0] ch;
    logic [NPROT-1:0][7:0] cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pst_ana_out_t ana;
    logic fault_n;
  } pst_state_t;

  pst_state_t r;
  pst_state_t n;

  logic acc;
  logic wr;
  logic setup;
  logic [2:0] rsel;
  logic [NPROT-1:0] go;
  logic [NPROT-1:0] par_err;
  logic [NPROT-1:0] busy;
  logic [NPROT-1:0] en;
  logic [NPROT-1:0][NCH-1:0] lo_set;
  logic [NPROT-1:0][NCH-1:0] lo_clr;
  logic [NPROT-1:0][NCH-1:0] hi_set;
  logic [NPROT-1:0][NCH-1:0] hi_clr;
  logic [NCH-1:0] act;
  logic [NCH-1:0] sel1h;
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  logic [1:0] mode_w;
  logic [3:0] lock;
  logic fault_req;
  logic keep;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] s;
    case (a)
      OFF_CTRL: s = 3'h0;
      OFF_VCFG: s = 3'h1;
      OFF_TCFG: s = 3'h2;
      OFF_STAT: s = 3'h3;
      OFF_VFLG: s = 3'h4;
      OFF_TFLG: s = 3'h5;
      OFF_AUX: s = 3'h6;
      default: s = 3'h7;
    endcase
    return s;
  endfunction

  function automatic logic [NCH-1:0] onehot(input logic [3:0] c);
    logic [NCH-1:0] v;
    v = '0;
    v[c] = 1'b1;
    return v;
  endfunction

  function automatic logic [NCH-1:0] act_mask(input int p, input logic [1:0] m,
                                              input logic [3:0] nc, input logic [3:0] lk);
    logic [NCH-1:0] v;
    v = '0;
    if (m == MODE_SINGLE) begin
      v = onehot(lk);
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (p == VP) begin
          v[i] = (4'(i) <= nc);
        end else begin
          v[i] = (i < NTEMP);
        end
      end
    end
    return v;
  endfunction

  function automatic logic [TW-1:0] dac08(input logic [TW-1:0] thr);
    logic [11:0] t;
    t = ({4'h0, thr} * 12'(DAC_NUM)) / 12'(DAC_DEN);
    return t[TW-1:0];
  endfunction

  // ************************************************************
  // Settings parity checkers
  // ************************************************************
  generate
    for (genvar gp = 0; gp < NPROT; gp++) begin : g_par
      assign en[gp] = (r.eng[gp] != ENG_IDLE);
      pst_cfg_parity u_par (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_en(en[gp]),
        .i_cfg({r.cfg[gp][19:0], r.mode[gp]}),
        .o_err(par_err[gp])
      );
    end
  endgenerate

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    n = r;
    st_set = '0;
    st_clr = '0;
    lo_set = '0;
    lo_clr = '0;
    hi_set = '0;
    hi_clr = '0;
    go = '0;
    act = '0;
    sel1h = '0;
    mode_w = MODE_OFF;
    lock = '0;
    setup = i_apb.psel & ~i_apb.penable;
    acc = i_apb.psel & i_apb.penable & r.pready;
    wr = acc & i_apb.pwrite;
    rsel = reg_sel(i_apb.paddr);
    keep = r.ctrl[CTRL_KEEP];
    fault_req = (|r.lo_flg) | (|r.hi_flg);
    for (int p = 0; p < NPROT; p++) begin
      busy[p] = (r.eng[p] != ENG_IDLE) & (r.eng[p] != ENG_RUN);
    end

    // Bus slave: answer in the cycle after setup
    n.pready = setup;
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (setup) begin
      n.pslverr = (rsel == 3'h7);
      if (~i_apb.pwrite) begin
        case (rsel)
          3'h0: n.prdata = r.ctrl;
          3'h1: n.prdata = r.cfg[VP];
          3'h2: n.prdata = r.cfg[TP];
          3'h3: n.prdata = {14'h0000, busy, 7'h00, r.stat};
          3'h4: n.prdata = {r.hi_flg[VP], r.lo_flg[VP]};
          3'h5: n.prdata = {r.hi_flg[TP], r.lo_flg[TP]};
          3'h6: n.prdata = {24'h00_0000, r.ana.aux_val};
          default: n.prdata = '0;
        endcase
      end
    end

    if (wr) begin
      case (rsel)
        3'h0: begin
          n.ctrl = i_apb.pwdata & CTRL_WMASK;
          go[VP] = i_apb.pwdata[CTRL_VGO];
          go[TP] = i_apb.pwdata[CTRL_TGO];
        end
        3'h1: n.cfg[VP] = i_apb.pwdata & VCFG_WMASK;
        3'h2: n.cfg[TP] = i_apb.pwdata & TCFG_WMASK;
        3'h3: st_clr = i_apb.pwdata[ST_W-1:0];
        3'h4: begin
          lo_clr[VP] = i_apb.pwdata[15:0];
          hi_clr[VP] = i_apb.pwdata[31:16];
        end
        3'h5: begin
          lo_clr[TP] = i_apb.pwdata[15:0];
          hi_clr[TP] = i_apb.pwdata[31:16];
        end
        default: begin
        end
      endcase
    end

    // Protector engines
    for (int p = 0; p < NPROT; p++) begin
      if (p == VP) begin
        mode_w = i_apb.pwdata[CTRL_VMODE+:2];
        lock = r.ctrl[CTRL_VLOCK+:4];
      end else begin
        mode_w = i_apb.pwdata[CTRL_TMODE+:2];
        lock = {1'b0, r.ctrl[CTRL_TLOCK+:3]};
      end
      act = act_mask(p, r.mode[p], r.cfg[p][CFG_NCELL+:4], lock);
      sel1h = onehot(r.ch[p]);
      st_set[ST_PAR + p] = par_err[p];
      n.ana.stim_hi[p] = 1'b0;
      n.ana.stim_lo[p] = 1'b0;
      n.ana.path_sel[p] = '0;
      case (r.eng[p])
        ENG_IDLE: begin
        end
        ENG_RUN: begin
          lo_set[p] = i_ana.lo_hit[p] & act;
          hi_set[p] = i_ana.hi_hit[p] & act;
        end
        ENG_PRE: begin
          if ((|r.lo_flg[p]) | (|r.hi_flg[p])) begin
            st_set[ST_ABORT] = 1'b1;
            n.eng[p] = ENG_IDLE;
          end else begin
            n.eng[p] = ENG_CMP_HI;
            n.cnt[p] = '0;
          end
        end
        ENG_CMP_HI: begin
          n.ana.stim_hi[p] = 1'b1;
          n.cnt[p] = r.cnt[p] + 8'h01;
          if ((|r.lo_flg[p]) | (|r.hi_flg[p])) begin
            st_set[ST_ABORT] = 1'b1;
            n.eng[p] = ENG_IDLE;
          end else if (r.cnt[p] == 8'(SETTLE_CYC)) begin
            st_set[ST_OCMP + p] = ~i_ana.over_cmp[p];
            st_set[ST_UCMP + p] = i_ana.under_cmp[p];
            n.ana.stim_hi[p] = 1'b0;
            n.eng[p] = ENG_CMP_LO;
            n.cnt[p] = '0;
          end
        end
        ENG_CMP_LO: begin
          n.ana.stim_lo[p] = 1'b1;
          n.cnt[p] = r.cnt[p] + 8'h01;
          if ((|r.lo_flg[p]) | (|r.hi_flg[p])) begin
            st_set[ST_ABORT] = 1'b1;
            n.eng[p] = ENG_IDLE;
          end else if (r.cnt[p] == 8'(SETTLE_CYC)) begin
            st_set[ST_OCMP + p] = i_ana.over_cmp[p];
            st_set[ST_UCMP + p] = ~i_ana.under_cmp[p];
            n.ana.stim_lo[p] = 1'b0;
            n.eng[p] = ENG_PATH;
            n.cnt[p] = '0;
            n.ch[p] = '0;
          end
        end
        ENG_PATH: begin
          if (act[r.ch[p]]) begin
            n.ana.path_sel[p] = sel1h;
            lo_set[p] = i_ana.lo_hit[p] & sel1h & {NCH{r.cnt[p] != 8'(SETTLE_CYC)}};
            n.cnt[p] = r.cnt[p] + 8'h01;
          end
          if (~act[r.ch[p]] | (r.cnt[p] == 8'(SETTLE_CYC))) begin
            if (act[r.ch[p]]) begin
              st_set[ST_PATH + p] = ~r.lo_flg[p][r.ch[p]] | ~fault_req;
              if (~keep) begin
                lo_clr[p] = sel1h;
              end
            end
            n.ana.path_sel[p] = '0;
            n.cnt[p] = '0;
            n.ch[p] = r.ch[p] + 4'h1;
            if (r.ch[p] == 4'hF) begin
              n.eng[p] = ENG_FORCE;
            end
          end
        end
        ENG_FORCE: begin
          if (act[r.ch[p]]) begin
            n.cnt[p] = r.cnt[p] + 8'h01;
            if (r.cnt[p] == 8'h00) begin
              hi_set[p] = sel1h;
            end
          end
          if (~act[r.ch[p]] | (r.cnt[p] == 8'(FORCE_CHK_CYC))) begin
            if (act[r.ch[p]]) begin
              st_set[ST_PATH + p] = ~r.hi_flg[p][r.ch[p]] | ~fault_req;
              if (~keep) begin
                hi_clr[p] = sel1h;
              end
            end
            n.cnt[p] = '0;
            n.ch[p] = r.ch[p] + 4'h1;
            if (r.ch[p] == 4'hF) begin
              n.eng[p] = ENG_IDLE;
            end
          end
        end
        default: n.eng[p] = ENG_IDLE;
      endcase

      // A go command overrides whatever the engine is doing
      if (go[p]) begin
        n.mode[p] = mode_w;
        n.cnt[p] = '0;
        n.ch[p] = '0;
        n.ana.stim_hi[p] = 1'b0;
        n.ana.stim_lo[p] = 1'b0;
        n.ana.path_sel[p] = '0;
        case (mode_w)
          MODE_OFF: n.eng[p] = ENG_IDLE;
          MODE_BUILT_IN_SELFTEST: n.eng[p] = ENG_PRE;
          default: n.eng[p] = ENG_RUN;
        endcase
      end
      n.ana.cmp_on[p] = (n.eng[p] != ENG_IDLE);
    end

    // Sticky flags: a set in the clear cycle wins
    n.stat = (r.stat & ~st_clr) | st_set;
    n.lo_flg = (r.lo_flg & ~lo_clr) | lo_set;
    n.hi_flg = (r.hi_flg & ~hi_clr) | hi_set;
    n.fault_n = ~(r.ctrl[CTRL_FEN] & fault_req);

    // Threshold converter readback
    case (r.ctrl[CTRL_MUX+:2])
      MUX_OV: n.ana.aux_val = dac08(r.cfg[VP][CFG_HI+:TW]);
      MUX_UV: n.ana.aux_val = dac08(r.cfg[VP][CFG_LO+:TW]);
      MUX_OT: n.ana.aux_val = r.cfg[TP][CFG_HI+:TW];
      MUX_UT: n.ana.aux_val = r.cfg[TP][CFG_LO+:TW];
      default: n.ana.aux_val = '0;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.cfg[VP] <= VCFG_RST;
      r.cfg[TP] <= TCFG_RST;
      r.fault_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_prdata = r.prdata;
  assign o_pready = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_ana = r.ana;
  assign o_fault_out_n = r.fault_n;

endmodule

// ### shared/pst_pkg.sv
// Constants, register map and carrier types of the protector self-test block
// Functional notes
// - Latch protector settings on enable, recheck periodically
// - Set per-protector settings parity error flag
// - Parity covers thresholds, mode, active cell count
// - Route threshold converter values to secondary converter
// - Voltage threshold readback equals 0.8 times setting
// - Voltage mode 10 plus go starts self-test
// - Voltage comparators checked above and below threshold
// - Each cell opened, flag and fault checked, cleared
// - Voltage path mismatch sets voltage path error
// - Over flags forced one by one and checked
// - Voltage comparators off after test; engine stays idle until next go
// - New go abandons test, follows current mode
// - Pre-existing fault before path step aborts test
// - Keep option leaves flags and fault asserted
// - Temperature mode 10 plus go starts self-test
// - Temperature comparators checked above and below threshold
// - Each temperature input pulled up and checked
// - Temperature comparators off after test; engine stays idle until next go
// - Fault output toggles per channel during self-test
package pst_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NPROT = 2;
  localparam int NCH = 16;
  localparam int NTEMP = 8;
  localparam int TW = 8;
  localparam int VP = 0;
  localparam int TP = 1;
  localparam int CFG_PW = 22;
  localparam int ST_W = 9;

  // ************************************************************
  // Modes and timing
  // ************************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RR = 2'h1;
  localparam logic [1:0] MODE_BUILT_IN_SELFTEST = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam int CLK_NS = 8;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCAN_NS = 1000;
  localparam int SCAN_CYC = SCAN_NS / CLK_NS;
  localparam int FORCE_CHK_CYC = 2;
  localparam int DAC_NUM = 4;
  localparam int DAC_DEN = 5;

  // ************************************************************
  // Register offsets and fields
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_VCFG = 8'h04;
  localparam logic [7:0] OFF_TCFG = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_VFLG = 8'h10;
  localparam logic [7:0] OFF_TFLG = 8'h14;
  localparam logic [7:0] OFF_AUX = 8'h18;
  localparam int CTRL_VMODE = 0;
  localparam int CTRL_VGO = 2;
  localparam int CTRL_TMODE = 4;
  localparam int CTRL_TGO = 6;
  localparam int CTRL_VLOCK = 8;
  localparam int CTRL_TLOCK = 12;
  localparam int CTRL_KEEP = 16;
  localparam int CTRL_FEN = 17;
  localparam int CTRL_MUX = 18;
  localparam logic [31:0] CTRL_WMASK = 32'h000F_7F33;
  localparam int CFG_HI = 0;
  localparam int CFG_LO = 8;
  localparam int CFG_NCELL = 16;
  localparam logic [31:0] VCFG_WMASK = 32'h000F_FFFF;
  localparam logic [31:0] TCFG_WMASK = 32'h0000_FFFF;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] VCFG_RST = 32'h000F_0000;
  localparam logic [31:0] TCFG_RST = 32'h0000_0000;
  localparam int ST_PAR = 0;
  localparam int ST_OCMP = 2;
  localparam int ST_UCMP = 4;
  localparam int ST_PATH = 6;
  localparam int ST_ABORT = 8;
  localparam logic [1:0] MUX_OV = 2'h0;
  localparam logic [1:0] MUX_UV = 2'h1;
  localparam logic [1:0] MUX_OT = 2'h2;
  localparam logic [1:0] MUX_UT = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_RUN, ENG_PRE, ENG_CMP_HI, ENG_CMP_LO, ENG_PATH, ENG_FORCE
  } pst_eng_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pst_apb_req_t;

  typedef struct packed {
    logic [NPROT-1:0] over_cmp;
    logic [NPROT-1:0] under_cmp;
    logic [NPROT-1:0][NCH-1:0] lo_hit;
    logic [NPROT-1:0][NCH-1:0] hi_hit;
  } pst_ana_in_t;

  typedef struct packed {
    logic [NPROT-1:0] cmp_on;
    logic [NPROT-1:0] stim_hi;
    logic [NPROT-1:0] stim_lo;
    logic [NPROT-1:0][NCH-1:0] path_sel;
    logic [TW-1:0] aux_val;
  } pst_ana_out_t;

endpackage

// ### design/pst_cfg_parity.sv
// Latched protector settings copy with background parity recheck
module pst_cfg_parity
  import pst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_en,
  input wire logic [CFG_PW-1:0] i_cfg,
  output logic o_err
);

  typedef struct packed {
    logic en_d;
    logic [CFG_PW-1:0] copy;
    logic par;
    logic [7:0] cnt;
    logic err;
  } pst_par_st_t;

  pst_par_st_t r;
  pst_par_st_t n;

  always_comb begin
    n = r;
    n.en_d = i_en;
    n.err = 1'b0;
    if (i_en & ~r.en_d) begin
      n.copy = i_cfg;
      n.par = ^i_cfg;
      n.cnt = '0;
    end else if (i_en) begin
      n.cnt = r.cnt + 8'h01;
      if (r.cnt == 8'(SCAN_CYC - 1)) begin
        n.cnt = '0;
        n.err = (^r.copy) != r.par;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_err = r.err;

endmodule

// ### sim/pst_selftest_chk.sv
// Port-level checker of the protector self-test block
module pst_selftest_chk
  import pst_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire pst_apb_req_t i_apb,
  input wire pst_ana_in_t i_ana,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire pst_ana_out_t o_ana,
  input wire logic o_fault_out_n
);
  // ********
  // Checks
  // ********
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire logic wr_ctrl = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite && i_apb.paddr == OFF_CTRL;

  property p_ready_after_setup;
    i_apb.psel && !i_apb.penable |=> o_pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready missing after setup");
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_with_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_reset_vals;
    $past(i_srst) |-> o_fault_out_n && !o_pready && o_ana == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset values");
  property p_vstart;
    wr_ctrl && o_fault_out_n && i_apb.pwdata[CTRL_VGO] && i_apb.pwdata[1:0] == MODE_BUILT_IN_SELFTEST |-> ##[1:3] o_ana.cmp_on[VP];
  endproperty
  a_vstart: assert property (p_vstart) else $error("voltage test did not start");
  property p_tstart;
    wr_ctrl && o_fault_out_n && i_apb.pwdata[CTRL_TGO] && i_apb.pwdata[5:4] == MODE_BUILT_IN_SELFTEST |-> ##[1:3] o_ana.cmp_on[TP];
  endproperty
  a_tstart: assert property (p_tstart) else $error("temperature test did not start");
  property p_stim_powered;
    |(o_ana.stim_hi | o_ana.stim_lo) |->
      (o_ana.cmp_on & (o_ana.stim_hi | o_ana.stim_lo)) == (o_ana.stim_hi | o_ana.stim_lo);
  endproperty
  a_stim_powered: assert property (p_stim_powered) else $error("stimulus without comparators");
  property p_path_onehot;
    $onehot0(o_ana.path_sel[VP]) && $onehot0(o_ana.path_sel[TP]);
  endproperty
  a_path_onehot: assert property (p_path_onehot) else $error("more than one channel under test");
  property p_temp_range;
    o_ana.path_sel[TP][NCH-1:NTEMP] == '0;
  endproperty
  a_temp_range: assert property (p_temp_range) else $error("temperature channel out of range");
endmodule

bind pst_protector_selftest pst_selftest_chk chk (.i_clk(i_clk), .i_srst(i_srst), .i_apb(i_apb), .i_ana(i_ana),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ana(o_ana), .o_fault_out_n(o_fault_out_n));

// ### sim/pst_protector_selftest_bench.sv
// Self-checking bench of the protector self-test block
module pst_protector_selftest_bench
  import pst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench
  // ********
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  pst_apb_req_t apb = '0;
  pst_ana_in_t ana = '0;
  pst_ana_out_t ana_o;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fault_n;
  logic bad_ov = 1'b0;
  logic [15:0] drop = 16'h0000;
  logic [31:0] q;
  logic e;
  logic [7:0] aux_exp [4] = '{8'h66, 8'h50, 8'h33, 8'h22};
  int err_count = 0;
  int tests_run = 0;
  int falls = 0;

  always #4 i_clk = ~i_clk;

  pst_protector_selftest dut (.i_clk(i_clk), .i_srst(i_srst), .i_apb(apb), .i_ana(ana), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_ana(ana_o), .o_fault_out_n(fault_n));

  always @(posedge i_clk) begin
    ana.over_cmp <= ana_o.stim_hi & {1'b1, ~bad_ov};
    ana.under_cmp <= ana_o.stim_lo;
    ana.lo_hit[VP] <= ana_o.path_sel[VP] & ~drop;
    ana.lo_hit[TP] <= ana_o.path_sel[TP];
  end
  always @(negedge fault_n) falls++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, exp, q & m);
  endtask
  task automatic clr;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_STAT, 32'h0000_01FF);
    wr(OFF_VFLG, 32'hFFFF_FFFF);
    wr(OFF_TFLG, 32'hFFFF_FFFF);
  endtask
  task automatic run(input logic [31:0] ctrl, input int bi);
    int n;
    n = 0;
    wr(OFF_CTRL, ctrl);
    do begin
      xfer(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (q[bi] !== 1'b0 && n < 400);
    chk("busy_end", 32'h0, {31'h0, q[bi]});
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    rd("ctrl", OFF_CTRL, 32'hFFFF_FFFF, CTRL_RST);
    rd("vcfg", OFF_VCFG, 32'hFFFF_FFFF, VCFG_RST);
    rd("tcfg", OFF_TCFG, 32'hFFFF_FFFF, TCFG_RST);
    rd("stat", OFF_STAT, 32'hFFFF_FFFF, 32'h0);
    rd("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0);
    chk("rd_slverr", 32'h1, {31'h0, e});
    wr(8'h1C, 32'h1234_5678);
    chk("wr_slverr", 32'h1, {31'h0, e});
    $display("test reset done");
    wr(OFF_VCFG, 32'h0003_6480);
    falls = 0;
    run(32'h0002_0006, 16);
    chk("fault_toggles", 32'h1, {31'h0, falls > 0});
    rd("v_stat", OFF_STAT, 32'h0003_01FF, 32'h0);
    rd("v_flags", OFF_VFLG, 32'hFFFF_FFFF, 32'h0);
    chk("v_cmp_off", 32'h0, {31'h0, ana_o.cmp_on[VP]});
    chk("v_pin", 32'h1, {31'h0, fault_n});
    $display("test voltage pass done");
    bad_ov = 1'b1;
    run(32'h0002_0006, 16);
    rd("ov_cmp_err", OFF_STAT, 32'h0000_01FF, 32'h0000_0004);
    bad_ov = 1'b0;
    clr();
    $display("test comparator fault done");
    drop = 16'h0004;
    run(32'h0003_0006, 16);
    rd("v_path_err", OFF_STAT, 32'h0000_0040, 32'h0000_0040);
    rd("kept_flags", OFF_VFLG, 32'h0000_FFFF, 32'h0000_000B);
    chk("kept_pin", 32'h0, {31'h0, fault_n});
    drop = 16'h0000;
    wr(OFF_STAT, 32'h0000_01FF);
    $display("test keep flags done");
    run(32'h0002_0006, 16);
    rd("abort", OFF_STAT, 32'h0000_0100, 32'h0000_0100);
    clr();
    $display("test abort done");
    wr(OFF_CTRL, 32'h0002_0060);
    repeat (10) @(posedge i_clk);
    wr(OFF_CTRL, 32'h0002_0050);
    rd("t_abandon", OFF_STAT, 32'h0002_0000, 32'h0);
    clr();
    run(32'h0002_0060, 17);
    rd("t_stat", OFF_STAT, 32'h0003_01FF, 32'h0);
    rd("t_flags", OFF_TFLG, 32'hFFFF_FFFF, 32'h0);
    chk("t_cmp_off", 32'h0, {31'h0, ana_o.cmp_on[TP]});
    $display("test temperature done");
    wr(OFF_TCFG, 32'h0000_2233);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CTRL, (32'(i) << CTRL_MUX) | 32'h0000_0077);
      rd("aux", OFF_AUX, 32'h0000_00FF, {24'h0, aux_exp[i]});
    end
    $display("test readback done");
    stop_test();
  end
endmodule
